// ---- hdl/dssar_regs.svh ----
`ifndef DSSAR_REGS_SVH
`define DSSAR_REGS_SVH

// register command addresses
`define DSSAR_ADDR_W 3
`define DSSAR_A_ECHO_HI 3'h0
`define DSSAR_A_ECHO_LO 3'h1
`define DSSAR_A_CYL 3'h2
`define DSSAR_A_ATTN 3'h3
`define DSSAR_A_COND 3'h4

// widths
`define DSSAR_WORD_W 18
`define DSSAR_HALF_W 9
`define DSSAR_CYL_W 8
`define DSSAR_COND_W 10

// halves of the 18-bit words, unit zero in the upper half
`define DSSAR_HI_MSB 17
`define DSSAR_HI_LSB 9
`define DSSAR_LO_MSB 8
`define DSSAR_LO_LSB 0

// condition register bit indices, word bit = 17 - status bit number
`define DSSAR_C_RESERVED 9
`define DSSAR_C_SEEK_INC 8
`define DSSAR_C_PACK_CHG 7
`define DSSAR_C_POSITIONING 6
`define DSSAR_C_ALT_WANTS 4
`define DSSAR_C_WCS_FAULT 3
`define DSSAR_C_END_CYL 2
`define DSSAR_C_OFFLINE 1
`define DSSAR_C_UNSAFE 0

// reset values and zero pads for store words
`define DSSAR_RST_WORD 18'h00000
`define DSSAR_RST_CYL 8'h00
`define DSSAR_RST_COND 10'h000
`define DSSAR_ZERO_PAD 8'h00
`define DSSAR_CYL_PAD 10'h000

`endif

// ---- hdl/dssar_pkg.sv ----
`include "dssar_regs.svh"

package dssar_pkg;

  // register bank state
  typedef struct packed {
    logic [`DSSAR_WORD_W-1:0] echo;
    logic [`DSSAR_CYL_W-1:0] cyl;
    logic [`DSSAR_WORD_W-1:0] attn;
    logic [`DSSAR_COND_W-1:0] cond;
    logic [`DSSAR_WORD_W-1:0] rd_data;
    logic rd_valid;
    logic irq;
  } dssar_state_t;

  // attention line synchroniser state
  typedef struct packed {
    logic [`DSSAR_WORD_W-1:0] s1;
    logic [`DSSAR_WORD_W-1:0] s2;
    logic [`DSSAR_WORD_W-1:0] s3;
  } dssar_sync_t;

endpackage

// ---- hdl/dssar_evt_if.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "dssar_regs.svh"

// attention line events handed from the synchroniser to the bank
interface dssar_evt_if;
  logic [`DSSAR_WORD_W-1:0] rise;
  logic [`DSSAR_WORD_W-1:0] fall;
  modport src (output rise, output fall);
  modport dst (input rise, input fall);
endinterface
`default_nettype wire

// ---- hdl/dssar_attn_sync.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "dssar_regs.svh"

module dssar_attn_sync
  import dssar_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // raw attention lines, asynchronous
  input wire logic [`DSSAR_WORD_W-1:0] attn_raw,
  // one-cycle edge events
  dssar_evt_if.src evt
);

  dssar_sync_t cur;
  dssar_sync_t next_cur;

  // two flops per line, a third one only feeds the edge detector
  always_comb begin
    next_cur = cur;
    next_cur.s1 = attn_raw;
    next_cur.s2 = cur.s1;
    next_cur.s3 = cur.s2;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  // per-line edges; s1 is never looked at here, only s2 and s3
  genvar i;
  generate
    for (i = 0; i < `DSSAR_WORD_W; i++) begin : g_edge
      assign evt.rise[i] = cur.s2[i] & ~cur.s3[i]; // R25
      assign evt.fall[i] = ~cur.s2[i] & cur.s3[i];
    end
  endgenerate

endmodule // dssar_attn_sync
`default_nettype wire

// ---- hdl/dssar_top.sv ----
// How it works
// R1: selected-device return is 18 bits, nine lines from each unit.
// R2: each half of the selected-device return loads by its own command.
// R3: a select captures the selected unit's eight cylinder position lines.
// R4: cylinder register holds last cylinder, unsigned, weights 128 down to 1.
// R5: host may load the cylinder register for fault isolation.
// R6: when unsafe, cylinder register holds the unsafe cause bits instead.
// R7: attention register takes nine lines per unit, one bit per drive.
// R8: each drive's event sets its own bit, same place as select.
// R9: attention bits accumulate, simultaneous too, and stay until cleared.
// R10: attention interrupt only while no data transfer command is busy.
// R11: attention reads as one 18-bit word, unit zero upper half.
// R12: host may load the attention register directly.
// R13: software clears seek or pack attention: select, read gate, control tag.
// R14: seek incomplete clears by restore; restore end gives new attention.
// R15: alternate channel release attention clears by a plain select.
// R16: drive condition is 10 bits, bits 0 to 7 read zero.
// R17: host may force any pattern into the drive condition register.
// R18: bit 8 means reserved to alternate channel; others then undefined.
// R19: bits 9, 10, 11: seek incomplete, pack change, positioning.
// R20: bit 13 says the alternate channel wants the drive.
// R21: bit 15 is end of cylinder, head 19 advanced to 20.
// R22: bits 14, 16, 17: write current fault, off-line, unsafe.
// R23: a select captures status and physical identity of the drive.
// R24: store words are right-adjusted in 18 bits.
// R25: attention lines pass a synchroniser before setting any bit.
`timescale 1ns/100ps
`default_nettype none
`include "dssar_regs.svh"

module dssar_top
  import dssar_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // register load and store commands
  input wire logic LOAD,
  input wire logic STORE,
  input wire logic [`DSSAR_ADDR_W-1:0] REG_ADDR,
  input wire logic [`DSSAR_WORD_W-1:0] LOAD_DATA,
  output logic [`DSSAR_WORD_W-1:0] STORE_DATA,
  output logic STORE_VALID,
  // drive select events
  input wire logic SELECT_LOAD,
  input wire logic SELECT_UNIT,
  input wire logic XFER_BUSY,
  // file electronics unit zero
  input wire logic [`DSSAR_HALF_W-1:0] UNIT0_DEVICE,
  input wire logic [`DSSAR_CYL_W-1:0] UNIT0_CYL_POS_BUS,
  input wire logic [`DSSAR_COND_W-1:0] UNIT0_STATUS,
  input wire logic [`DSSAR_HALF_W-1:0] UNIT0_ATTN,
  // file electronics unit one
  input wire logic [`DSSAR_HALF_W-1:0] UNIT1_DEVICE,
  input wire logic [`DSSAR_CYL_W-1:0] UNIT1_CYL_POS_BUS,
  input wire logic [`DSSAR_COND_W-1:0] UNIT1_STATUS,
  input wire logic [`DSSAR_HALF_W-1:0] UNIT1_ATTN,
  // attention interrupt
  output logic ATTN_IRQ
);

  dssar_state_t cur;
  dssar_state_t next_cur;
  dssar_evt_if evt ();

  logic [`DSSAR_WORD_W-1:0] attn_raw;
  logic [`DSSAR_CYL_W-1:0] sel_cyl;
  logic [`DSSAR_COND_W-1:0] sel_status;
  logic ld_echo_hi;
  logic ld_echo_lo;
  logic ld_cyl;
  logic ld_attn;
  logic ld_cond;

  // unit zero owns the upper nine bits, unit one the lower nine
  assign attn_raw = {UNIT0_ATTN, UNIT1_ATTN}; // R7 R11

  // attention lines are asynchronous to CLK
  dssar_attn_sync u_sync (
    .clk(CLK),
    .rst(SYS_RST),
    .attn_raw(attn_raw),
    .evt(evt)
  );

  // the shared buses of the selected unit only
  assign sel_cyl = SELECT_UNIT ? UNIT1_CYL_POS_BUS : UNIT0_CYL_POS_BUS;
  assign sel_status = SELECT_UNIT ? UNIT1_STATUS : UNIT0_STATUS;

  // load command decode
  assign ld_echo_hi = LOAD && (REG_ADDR == `DSSAR_A_ECHO_HI);
  assign ld_echo_lo = LOAD && (REG_ADDR == `DSSAR_A_ECHO_LO);
  assign ld_cyl = LOAD && (REG_ADDR == `DSSAR_A_CYL);
  assign ld_attn = LOAD && (REG_ADDR == `DSSAR_A_ATTN);
  assign ld_cond = LOAD && (REG_ADDR == `DSSAR_A_COND);

  // next state of the whole bank
  always_comb begin
    next_cur = cur;
    next_cur.rd_valid = 1'b0;

    // select captures identity, position and status of the drive
    if (SELECT_LOAD) begin
      next_cur.echo = {UNIT0_DEVICE, UNIT1_DEVICE}; // R1 R23
      // unsafe drives put their cause bits on the same lines
      next_cur.cyl = sel_cyl; // R3 R4 R6
      next_cur.cond = sel_status; // R23 R18 R19 R20 R21 R22
    end

    // host loads win over a select in the same cycle
    if (ld_echo_hi) begin
      next_cur.echo[`DSSAR_HI_MSB:`DSSAR_HI_LSB] =
        LOAD_DATA[`DSSAR_LO_MSB:`DSSAR_LO_LSB]; // R2
    end
    if (ld_echo_lo) begin
      next_cur.echo[`DSSAR_LO_MSB:`DSSAR_LO_LSB] =
        LOAD_DATA[`DSSAR_LO_MSB:`DSSAR_LO_LSB]; // R2
    end
    if (ld_cyl) begin
      next_cur.cyl = LOAD_DATA[`DSSAR_CYL_W-1:0]; // R5
    end
    if (ld_cond) begin
      next_cur.cond = LOAD_DATA[`DSSAR_COND_W-1:0]; // R17
    end

    // a drive drops its line once its cause is cleared; the bit follows
    next_cur.attn = cur.attn & ~evt.fall; // R13 R14 R15
    if (ld_attn) begin
      next_cur.attn = LOAD_DATA; // R12
    end
    // set wins over any clear so no event is lost
    next_cur.attn = next_cur.attn | evt.rise; // R8 R9 R14

    // registered interrupt, held off during data transfer commands
    next_cur.irq = (|cur.attn) && !XFER_BUSY; // R10

    // store answers one cycle after the command, right-adjusted
    if (STORE) begin
      next_cur.rd_valid = 1'b1;
      case (REG_ADDR)
        `DSSAR_A_ECHO_HI,
        `DSSAR_A_ECHO_LO: begin
          next_cur.rd_data = cur.echo; // R1
        end
        `DSSAR_A_CYL: begin
          next_cur.rd_data = {`DSSAR_CYL_PAD, cur.cyl}; // R24
        end
        `DSSAR_A_ATTN: begin
          next_cur.rd_data = cur.attn; // R11
        end
        `DSSAR_A_COND: begin
          // upper bits and bit 7 read as zero
          next_cur.rd_data = {`DSSAR_ZERO_PAD, cur.cond}; // R16 R24
        end
        default: begin
          next_cur.rd_data = `DSSAR_RST_WORD;
        end
      endcase
    end
  end

  // single state register
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      cur.echo <= `DSSAR_RST_WORD;
      cur.cyl <= `DSSAR_RST_CYL;
      cur.attn <= `DSSAR_RST_WORD;
      cur.cond <= `DSSAR_RST_COND;
      cur.rd_data <= `DSSAR_RST_WORD;
      cur.rd_valid <= 1'b0;
      cur.irq <= 1'b0;
    end else begin
      cur <= next_cur;
    end
  end

  // outputs straight from flops
  assign STORE_DATA = cur.rd_data;
  assign STORE_VALID = cur.rd_valid;
  assign ATTN_IRQ = cur.irq;

  // busy transfer command masks the interrupt on the next edge
  a_irq_busy_gate: // R10
  assert property (@(posedge CLK) disable iff (SYS_RST)
    XFER_BUSY |=> !ATTN_IRQ)
  else $error("attention interrupt raised while transfer busy");

  // pending attention with idle channel raises interrupt
  a_irq_raise: // R10
  assert property (@(posedge CLK) disable iff (SYS_RST)
    ((|cur.attn) && !XFER_BUSY) |=> ATTN_IRQ)
  else $error("attention interrupt missing");

  // an edge always leaves its bit set
  a_attn_set_wins: // R8
  assert property (@(posedge CLK) disable iff (SYS_RST)
    (|evt.rise) |=> ((cur.attn & $past(evt.rise)) == $past(evt.rise)))
  else $error("attention event lost");

  // without a fall or a load every set bit stays set
  a_attn_sticky: // R9
  assert property (@(posedge CLK) disable iff (SYS_RST)
    (!ld_attn && !(|evt.fall)) |=>
      ((cur.attn & $past(cur.attn)) == $past(cur.attn)))
  else $error("attention bit dropped without a clear");

  // select captures identity from both units
  a_sel_echo: // R23
  assert property (@(posedge CLK) disable iff (SYS_RST)
    (SELECT_LOAD && !LOAD) |=>
      (cur.echo == $past({UNIT0_DEVICE, UNIT1_DEVICE})))
  else $error("selected-device return not captured");

  // select captures the selected unit's position and status
  a_sel_cyl_cond: // R3
  assert property (@(posedge CLK) disable iff (SYS_RST)
    (SELECT_LOAD && !LOAD) |=>
      (cur.cyl == $past(sel_cyl)) && (cur.cond == $past(sel_status)))
  else $error("cylinder or status not captured on select");

  // an upper-half load leaves the lower half alone
  a_echo_half: // R2
  assert property (@(posedge CLK) disable iff (SYS_RST)
    (ld_echo_hi && !SELECT_LOAD) |=>
      (cur.echo[`DSSAR_LO_MSB:`DSSAR_LO_LSB] ==
       $past(cur.echo[`DSSAR_LO_MSB:`DSSAR_LO_LSB])) &&
      (cur.echo[`DSSAR_HI_MSB:`DSSAR_HI_LSB] ==
       $past(LOAD_DATA[`DSSAR_LO_MSB:`DSSAR_LO_LSB])))
  else $error("half load of selected-device return wrong");

  // attention store returns all 18 bits one cycle later
  a_store_attn: // R11
  assert property (@(posedge CLK) disable iff (SYS_RST)
    (STORE && (REG_ADDR == `DSSAR_A_ATTN)) |=>
      STORE_VALID && (STORE_DATA == $past(cur.attn)))
  else $error("attention store word wrong");

  // condition store keeps upper eight bits at zero
  a_store_cond: // R16
  assert property (@(posedge CLK) disable iff (SYS_RST)
    (STORE && (REG_ADDR == `DSSAR_A_COND)) |=>
      STORE_VALID && (STORE_DATA[17:10] == `DSSAR_ZERO_PAD) &&
      (STORE_DATA[9:0] == $past(cur.cond)))
  else $error("condition store word wrong");

  // store valid is raised only in the cycle after a store command
  a_store_pulse: // R24
  assert property (@(posedge CLK) disable iff (SYS_RST)
    STORE_VALID |-> $past(STORE))
  else $error("store answer without a command");

  // host load of the cylinder register lands next cycle
  a_cyl_load: // R5
  assert property (@(posedge CLK) disable iff (SYS_RST)
    ld_cyl |=> (cur.cyl == $past(LOAD_DATA[`DSSAR_CYL_W-1:0])))
  else $error("cylinder load lost");

  // forced condition pattern lands unchanged
  a_cond_load: // R17
  assert property (@(posedge CLK) disable iff (SYS_RST)
    ld_cond |=> (cur.cond == $past(LOAD_DATA[`DSSAR_COND_W-1:0])))
  else $error("condition load lost");

  // a lower-half load leaves the upper half alone
  a_echo_lo_half: // R2
  assert property (@(posedge CLK) disable iff (SYS_RST)
    (ld_echo_lo && !SELECT_LOAD) |=>
      (cur.echo[`DSSAR_HI_MSB:`DSSAR_HI_LSB] ==
       $past(cur.echo[`DSSAR_HI_MSB:`DSSAR_HI_LSB])) &&
      (cur.echo[`DSSAR_LO_MSB:`DSSAR_LO_LSB] ==
       $past(LOAD_DATA[`DSSAR_LO_MSB:`DSSAR_LO_LSB])))
  else $error("lower half load of selected-device return wrong");

  // direct attention load, a same-cycle event still sets its bit
  a_attn_load: // R12
  assert property (@(posedge CLK) disable iff (SYS_RST)
    ld_attn |=> (cur.attn == ($past(LOAD_DATA) | $past(evt.rise))))
  else $error("attention load lost");

  // a dropped line clears its bit unless a load rewrites it
  a_attn_fall_clear: // R15
  assert property (@(posedge CLK) disable iff (SYS_RST)
    ((|evt.fall) && !ld_attn) |=>
      ((cur.attn & $past(evt.fall)) == `DSSAR_RST_WORD))
  else $error("attention bit not cleared");

  // echo store returns the whole word, both halves
  a_store_echo: // R1
  assert property (@(posedge CLK) disable iff (SYS_RST)
    (STORE && (REG_ADDR == `DSSAR_A_ECHO_LO)) |=>
      STORE_VALID && (STORE_DATA == $past(cur.echo)))
  else $error("selected-device store word wrong");

  // cylinder store is right-adjusted with a zero pad
  a_store_cyl: // R24
  assert property (@(posedge CLK) disable iff (SYS_RST)
    (STORE && (REG_ADDR == `DSSAR_A_CYL)) |=>
      STORE_VALID && (STORE_DATA == {`DSSAR_CYL_PAD, $past(cur.cyl)}))
  else $error("cylinder store word wrong");

  // unmapped addresses still answer, with an all-zero word
  a_store_unmapped: // R24
  assert property (@(posedge CLK) disable iff (SYS_RST)
    (STORE && (REG_ADDR > `DSSAR_A_COND)) |=>
      STORE_VALID && (STORE_DATA == `DSSAR_RST_WORD))
  else $error("unmapped store word not zero");

endmodule // dssar_top
`default_nettype wire

// ---- tb/dssar_fe_model.sv ----
`timescale 1ns/100ps
`default_nettype none

// both file electronics units; index 0 is unit zero
module dssar_fe_model (
  // clock
  input wire logic clk,
  // lines toward the adapter, held as levels
  output logic [1:0][8:0] dev,
  output logic [1:0][7:0] cyl,
  output logic [1:0][9:0] stat,
  output logic [1:0][8:0] at
);
  // all drives quiet at power up
  initial begin
    dev = '0;
    cyl = '0;
    stat = '0;
    at = '0;
  end

  // one unit presents its selected drive's identity, cylinder and status
  task put(input int u, input logic [8:0] d, input logic [7:0] c,
    input logic [9:0] s);
    @(posedge clk);
    dev[u] <= d;
    cyl[u] <= c;
    stat[u] <= s;
  endtask

  // attention levels of both units; a drive drops its line once the
  // clearing sequence or restore is done, and raises it again when
  // a restore completes
  task drive_attn(input logic [8:0] a0, input logic [8:0] a1);
    @(posedge clk);
    at[0] <= a0;
    at[1] <= a1;
  endtask
endmodule // dssar_fe_model
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/100ps
`default_nettype none

module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ld = 1'b0;
  logic st_cmd = 1'b0;
  logic sel = 1'b0;
  logic sel_u = 1'b0;
  logic busy = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [17:0] ld_data = 18'h00000;
  logic [17:0] sd;
  logic [17:0] rd;
  logic sv;
  logic irq;
  logic [1:0][8:0] dev;
  logic [1:0][7:0] cyl;
  logic [1:0][9:0] stat;
  logic [1:0][8:0] at;
  int fail_count = 0;
  int n_checks = 0;

  dssar_top uut (.CLK(clk), .SYS_RST(rst), .LOAD(ld), .STORE(st_cmd),
    .REG_ADDR(addr), .LOAD_DATA(ld_data), .STORE_DATA(sd),
    .STORE_VALID(sv), .SELECT_LOAD(sel), .SELECT_UNIT(sel_u),
    .XFER_BUSY(busy), .UNIT0_DEVICE(dev[0]),
    .UNIT0_CYL_POS_BUS(cyl[0]), .UNIT0_STATUS(stat[0]),
    .UNIT0_ATTN(at[0]), .UNIT1_DEVICE(dev[1]),
    .UNIT1_CYL_POS_BUS(cyl[1]), .UNIT1_STATUS(stat[1]),
    .UNIT1_ATTN(at[1]), .ATTN_IRQ(irq));
  dssar_fe_model fe (.clk(clk), .dev(dev), .cyl(cyl), .stat(stat),
    .at(at));

  // 100 MHz clock
  initial begin
    forever #5 clk = ~clk;
  end

  // word compare under a mask; upper store bits may be don't-care
  task chk(input string nm, input logic [17:0] m, input logic [17:0] e,
    input logic [17:0] g);
    n_checks++;
    if ((g & m) !== (e & m)) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e & m, g & m);
    end
  endtask
  task chk1(input string nm, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask

  // bus cycles, launched just after an edge and taken at the next
  task ldr(input logic [2:0] a, input logic [17:0] d);
    @(posedge clk);
    ld <= 1'b1;
    addr <= a;
    ld_data <= d;
    @(posedge clk);
    ld <= 1'b0;
  endtask
  task rdr(input logic [2:0] a);
    @(posedge clk);
    st_cmd <= 1'b1;
    addr <= a;
    @(posedge clk);
    st_cmd <= 1'b0;
    #1;
    chk1("store_valid", 1'b1, sv);
    rd = sd;
  endtask
  task pick(input logic u);
    @(posedge clk);
    sel <= 1'b1;
    sel_u <= u;
    @(posedge clk);
    sel <= 1'b0;
  endtask
  task wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // everything clear after reset, unmapped address included
  task s_reset;
    for (int a = 0; a < 6; a++) begin
      rdr(a[2:0]);
      chk("reset_word", 18'h3FFFF, 18'h00000, rd);
    end
    chk1("irq_idle", 1'b0, irq);
  endtask

  // select captures identity of both units, cylinder and status of the picked unit, each unit in turn
  task s_select;
    fe.put(0, 9'h004, 8'hA5, 10'h155);
    fe.put(1, 9'h100, 8'h81, 10'h201);
    pick(1'b0);
    rdr(3'h0);
    chk("echo", 18'h3FFFF, 18'h00900, rd);
    rdr(3'h2);
    chk("cyl0", 18'h000FF, 18'h000A5, rd);
    rdr(3'h4);
    chk("cond0", 18'h007FF, 18'h00155, rd);
    pick(1'b1);
    rdr(3'h2);
    chk("cyl1", 18'h000FF, 18'h00081, rd);
    rdr(3'h4);
    chk("cond1", 18'h007FF, 18'h00201, rd);
  endtask

  // host loads for fault isolation, halves of the echo separately
  task s_loads;
    ldr(3'h0, 18'h001AB);
    ldr(3'h1, 18'h00055);
    rdr(3'h1);
    chk("echo_halves", 18'h3FFFF, 18'h35655, rd);
    ldr(3'h2, 18'h0003C);
    rdr(3'h2);
    chk("cyl_load", 18'h000FF, 18'h0003C, rd);
    ldr(3'h4, 18'h002A5);
    rdr(3'h4);
    chk("cond_load", 18'h003FF, 18'h002A5, rd);
    ldr(3'h4, 18'h3FFFF);
    rdr(3'h4);
    chk("cond_bit7", 18'h007FF, 18'h003FF, rd);
    ldr(3'h3, 18'h24681);
    rdr(3'h3);
    chk("attn_load", 18'h3FFFF, 18'h24681, rd);
  endtask

  // simultaneous events, gating by a busy transfer, accumulation
  task s_attn;
    ldr(3'h3, 18'h00000);
    fe.drive_attn(9'h101, 9'h002);
    wt(5);
    rdr(3'h3);
    chk("attn_both", 18'h3FFFF, 18'h20202, rd);
    chk1("irq_set", 1'b1, irq);
    @(posedge clk);
    busy <= 1'b1;
    wt(2);
    chk1("irq_busy", 1'b0, irq);
    @(posedge clk);
    busy <= 1'b0;
    wt(2);
    chk1("irq_back", 1'b1, irq);
    fe.drive_attn(9'h101, 9'h012);
    wt(25);
    rdr(3'h3);
    chk("attn_accum", 18'h3FFFF, 18'h20212, rd);
    ldr(3'h3, 18'h00000);
    wt(2);
    rdr(3'h3);
    chk("attn_clear", 18'h3FFFF, 18'h00000, rd);
    chk1("irq_clear", 1'b0, irq);
  endtask

  // clearing by select, then a restore giving a fresh attention
  task s_clear;
    fe.drive_attn(9'h000, 9'h000);
    wt(5);
    fe.drive_attn(9'h010, 9'h000);
    wt(5);
    rdr(3'h3);
    chk("attn_rel", 18'h3FFFF, 18'h02000, rd);
    pick(1'b0);
    fe.drive_attn(9'h000, 9'h000);
    wt(5);
    rdr(3'h3);
    chk("attn_gone", 18'h3FFFF, 18'h00000, rd);
    fe.drive_attn(9'h010, 9'h000);
    wt(5);
    rdr(3'h3);
    chk("attn_again", 18'h3FFFF, 18'h02000, rd);
  endtask

  // mid-run reset clears the bank; a line still high sets again later
  task s_rerst;
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rdr(3'h3);
    chk("attn_rst", 18'h3FFFF, 18'h00000, rd);
    chk1("irq_rst", 1'b0, irq);
    wt(5);
    rdr(3'h3);
    chk("attn_relive", 18'h3FFFF, 18'h02000, rd);
  endtask

  // verdict and end of run
  task complete_run;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // main sequence after a three cycle reset
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    s_reset;
    s_select;
    s_loads;
    s_attn;
    s_clear;
    s_rerst;
    complete_run;
  end

  // hang guard, several times the expected run
  initial begin
    #20000;
    fail_count++;
    complete_run;
  end
endmodule // tb
`default_nettype wire
